// [ocau_pkg.sv]
// Purpose: shared constants for the ones-complement arithmetic unit
// Assumes: 18-bit words, word-indexed register port
// Notes: opcode values are the instruction function codes
`default_nettype none
package ocau_pkg;
  localparam int W = 18;
  localparam int CW = 6;
  // register indices on the plain port
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_UPPER = 3'h1;
  localparam logic [2:0] REG_LOWER = 3'h2;
  localparam logic [2:0] REG_MEM0 = 3'h3;
  localparam logic [2:0] REG_MEM1 = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  // command word fields
  localparam int F_HI = 17;
  localparam int F_LO = 12;
  localparam int SUB_HI = 11;
  localparam int SUB_LO = 6;
  localparam int CNT_HI = 5;
  // function codes
  localparam logic [5:0] OP_ADD_A = 6'h0c;
  localparam logic [5:0] OP_ADD_B = 6'h0d;
  localparam logic [5:0] OP_SUB_A = 6'h0e;
  localparam logic [5:0] OP_SUB_B = 6'h0f;
  localparam logic [5:0] OP_DADD_A = 6'h10;
  localparam logic [5:0] OP_DADD_B = 6'h11;
  localparam logic [5:0] OP_DSUB_A = 6'h12;
  localparam logic [5:0] OP_DSUB_B = 6'h13;
  localparam logic [5:0] OP_MUL_A = 6'h14;
  localparam logic [5:0] OP_MUL_B = 6'h15;
  localparam logic [5:0] OP_DIV_A = 6'h16;
  localparam logic [5:0] OP_DIV_B = 6'h17;
  localparam logic [5:0] OP_EXT = 6'h28;
  localparam logic [5:0] SUB_SHR_UP = 6'h21;
  localparam logic [5:0] SUB_SHL_UP = 6'h25;
  // loop counts
  localparam logic [CW-1:0] MUL_COUNT = 6'h13;
  localparam logic [CW-1:0] DIV_COUNT = 6'h12;
  // reset values
  localparam logic [W-1:0] WORD_RST = 18'h00000;
  localparam logic [CW-1:0] CNT_RST = 6'h00;
endpackage : ocau_pkg
`default_nettype wire

// [ocau_adder_if.sv]
// Purpose: link between the sequencer and the subtractive adder
// Assumes: purely combinational adder
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface ocau_adder_if;
  logic [17:0] x;
  logic [17:0] d;
  logic [17:0] sum;
  logic borrow;
  modport seq (output x, output d, input sum, input borrow);
  modport unit (input x, input d, output sum, output borrow);
endinterface : ocau_adder_if
`default_nettype wire

// [ocau_adder.sv]
// Purpose: subtractive ones-complement adder, sum = x - (not d)
// Assumes: operands in ones-complement form
// Notes: borrow is the end-around borrow of the subtraction
`timescale 1ns/1ps
`default_nettype none
module ocau_adder (
  ocau_adder_if.unit a
);
  logic [18:0] diff;
  logic [17:0] nd;
  assign nd = ~a.d;
  // equal operands give +0, never -0
  assign diff = {1'b0, a.x} - {1'b0, nd};
  assign a.borrow = diff[18];
  assign a.sum = diff[17:0] - {17'h00000, diff[18]};
endmodule : ocau_adder
`default_nettype wire

// [ocau_arith_unit.sv]
// Purpose: add, subtract, multiply, divide and upper-word shifts
// Assumes: operands written over the register port before the command
// Notes: a command write while busy is ignored
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ocau_arith_unit (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [17:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [17:0] rd_data_out,
  output logic busy_out,
  output logic overflow_out
);
  typedef enum logic [4:0] {
    ST_IDLE,
    ST_ADD_LO,
    ST_ADD_HI,
    ST_MUL_SETUP,
    ST_MUL_ADD,
    ST_CLR_NEXT,
    ST_LOAD_NEXT,
    ST_TO_TEMP,
    ST_COPY_CNT,
    ST_RETURN,
    ST_TEST,
    ST_MUL_FIX,
    ST_DIV_SETUP,
    ST_DIV_CHECK,
    ST_DIV_STEP,
    ST_DIV_FIX,
    ST_SH_TEMP,
    ST_SH_BACK
  } ocau_state_t;

  ocau_state_t state_reg;
  logic [17:0] cmd_reg;
  logic [17:0] upper_word_register_reg;
  logic [17:0] low_word_register_reg;
  logic [17:0] mem0_reg;
  logic [17:0] mem1_reg;
  logic [17:0] latch_reg;
  logic [17:0] upper_tmp_reg;
  logic [17:0] lower_tmp_reg;
  logic [5:0] count_current_stage_reg;
  logic [5:0] count_next_stage_reg;
  logic sign_a_reg;
  logic sign_b_reg;
  logic add_pend_reg;
  logic is_sub_reg;
  logic is_dbl_reg;
  logic shl_reg;
  logic div_ovf_reg;
  logic busy_reg;
  logic overflow_reg;
  logic [17:0] rd_data_reg;

  ocau_adder_if add_if ();

  ocau_adder u_adder (
    .a(add_if)
  );

  // decode of the register port
  wire wr_cmd = wr_en_in && (addr_in == ocau_pkg::REG_CMD);
  wire wr_up = wr_en_in && (addr_in == ocau_pkg::REG_UPPER);
  wire wr_lo = wr_en_in && (addr_in == ocau_pkg::REG_LOWER);
  wire wr_m0 = wr_en_in && (addr_in == ocau_pkg::REG_MEM0);
  wire wr_m1 = wr_en_in && (addr_in == ocau_pkg::REG_MEM1);
  wire wr_st = wr_en_in && (addr_in == ocau_pkg::REG_STATUS);
  wire start = wr_cmd && !busy_reg;

  wire [5:0] f_code = wr_data_in[ocau_pkg::F_HI:ocau_pkg::F_LO];
  wire [5:0] sub_code = wr_data_in[ocau_pkg::SUB_HI:ocau_pkg::SUB_LO];
  wire [5:0] sh_cnt = wr_data_in[ocau_pkg::CNT_HI:0];
  wire op_add = (f_code == ocau_pkg::OP_ADD_A) || (f_code == ocau_pkg::OP_ADD_B);
  wire op_sub = (f_code == ocau_pkg::OP_SUB_A) || (f_code == ocau_pkg::OP_SUB_B);
  wire op_dadd = (f_code == ocau_pkg::OP_DADD_A) || (f_code == ocau_pkg::OP_DADD_B);
  wire op_dsub = (f_code == ocau_pkg::OP_DSUB_A) || (f_code == ocau_pkg::OP_DSUB_B);
  wire op_mul = (f_code == ocau_pkg::OP_MUL_A) || (f_code == ocau_pkg::OP_MUL_B);
  wire op_div = (f_code == ocau_pkg::OP_DIV_A) || (f_code == ocau_pkg::OP_DIV_B);
  wire op_shr = (f_code == ocau_pkg::OP_EXT) && (sub_code == ocau_pkg::SUB_SHR_UP);
  wire op_shl = (f_code == ocau_pkg::OP_EXT) && (sub_code == ocau_pkg::SUB_SHL_UP);
  wire op_arith = op_add || op_sub || op_dadd || op_dsub;
  wire op_subtract = op_sub || op_dsub;

  // operand magnitudes and signs (top bit is the sign)
  wire up_neg = upper_word_register_reg[17];
  wire lo_neg = low_word_register_reg[17];
  wire m0_neg = mem0_reg[17];
  wire [17:0] lo_mag = lo_neg ? ~low_word_register_reg : low_word_register_reg;
  wire [17:0] m0_mag = m0_neg ? ~mem0_reg : mem0_reg;
  wire [35:0] pair = {upper_word_register_reg, low_word_register_reg};
  wire [35:0] pair_mag = up_neg ? ~pair : pair;
  wire [35:0] pair_inv = ~pair;

  // divide step: pair shifted left, trial subtract on the new upper word
  wire [35:0] pair_shl = {pair[34:0], 1'b0};

  // adder input selection
  wire sel_lo = (state_reg == ST_ADD_LO);
  wire sel_div = (state_reg == ST_DIV_STEP);
  assign add_if.x = sel_lo ? low_word_register_reg
                  : (sel_div ? pair_shl[35:18] : upper_word_register_reg);
  assign add_if.d = latch_reg;
  wire [17:0] add_sum = add_if.sum;
  wire add_borrow = add_if.borrow;

  // shift of the upper word into its temp
  wire [17:0] up_shr = {upper_word_register_reg[17], upper_word_register_reg[17:1]};
  wire [17:0] up_shl = {upper_word_register_reg[16:0], upper_word_register_reg[17]};

  wire cnt_zero_cmd = (sh_cnt == ocau_pkg::CNT_RST);
  wire cnt_last = (count_current_stage_reg == 6'h01);
  wire ovf_set = (state_reg == ST_DIV_CHECK) && !add_borrow;
  wire ovf_clr = wr_st && wr_data_in[ocau_pkg::ST_OVF_BIT];

  // read mux, unmapped indices read as zero
  wire [17:0] status_word = {16'h0000, overflow_reg, busy_reg};
  wire [17:0] rd_mux = (addr_in == ocau_pkg::REG_CMD) ? cmd_reg
                     : (addr_in == ocau_pkg::REG_UPPER) ? upper_word_register_reg
                     : (addr_in == ocau_pkg::REG_LOWER) ? low_word_register_reg
                     : (addr_in == ocau_pkg::REG_MEM0) ? mem0_reg
                     : (addr_in == ocau_pkg::REG_MEM1) ? mem1_reg
                     : (addr_in == ocau_pkg::REG_STATUS) ? status_word
                     : ocau_pkg::WORD_RST;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_reg <= ocau_pkg::WORD_RST;
    end
    else
    begin
      rd_data_reg <= rd_en_in ? rd_mux : ocau_pkg::WORD_RST;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      overflow_reg <= 1'b0;
    end
    else
    begin
      overflow_reg <= ovf_set || (overflow_reg && !ovf_clr);
    end
  end

  // operand holding words; frozen while a command runs
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem0_reg <= ocau_pkg::WORD_RST;
      mem1_reg <= ocau_pkg::WORD_RST;
      cmd_reg <= ocau_pkg::WORD_RST;
    end
    else
    begin
      if (wr_m0 && !busy_reg)
        mem0_reg <= wr_data_in;
      if (wr_m1 && !busy_reg)
        mem1_reg <= wr_data_in;
      if (start)
        cmd_reg <= wr_data_in;
    end
  end

  // sequencer
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= ST_IDLE;
      upper_word_register_reg <= ocau_pkg::WORD_RST;
      low_word_register_reg <= ocau_pkg::WORD_RST;
      latch_reg <= ocau_pkg::WORD_RST;
      upper_tmp_reg <= ocau_pkg::WORD_RST;
      lower_tmp_reg <= ocau_pkg::WORD_RST;
      count_current_stage_reg <= ocau_pkg::CNT_RST;
      count_next_stage_reg <= ocau_pkg::CNT_RST;
      sign_a_reg <= 1'b0;
      sign_b_reg <= 1'b0;
      add_pend_reg <= 1'b0;
      is_sub_reg <= 1'b0;
      is_dbl_reg <= 1'b0;
      shl_reg <= 1'b0;
      div_ovf_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (wr_up)
            upper_word_register_reg <= wr_data_in;
          if (wr_lo)
            low_word_register_reg <= wr_data_in;
          if (start && op_arith)
          begin
            is_sub_reg <= op_subtract;
            is_dbl_reg <= op_dadd || op_dsub;
            latch_reg <= op_subtract ? ~mem0_reg : mem0_reg;
            busy_reg <= 1'b1;
            state_reg <= ST_ADD_LO;
          end
          else if (start && op_mul)
          begin
            busy_reg <= 1'b1;
            state_reg <= ST_MUL_SETUP;
          end
          else if (start && op_div)
          begin
            busy_reg <= 1'b1;
            state_reg <= ST_DIV_SETUP;
          end
          // zero count leaves the word alone and never goes busy
          else if (start && (op_shr || op_shl) && !cnt_zero_cmd)
          begin
            shl_reg <= op_shl;
            count_current_stage_reg <= sh_cnt;
            busy_reg <= 1'b1;
            state_reg <= ST_SH_TEMP;
          end
        end
        ST_ADD_LO:
        begin
          low_word_register_reg <= add_sum;
          if (is_dbl_reg)
          begin
            // second pass brings in the Y+1 word
            latch_reg <= is_sub_reg ? ~mem1_reg : mem1_reg;
            state_reg <= ST_ADD_HI;
          end
          else
          begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_ADD_HI:
        begin
          upper_word_register_reg <= add_sum;
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_MUL_SETUP:
        begin
          sign_a_reg <= m0_neg;
          sign_b_reg <= lo_neg;
          latch_reg <= m0_mag;
          low_word_register_reg <= lo_mag;
          upper_word_register_reg <= ocau_pkg::WORD_RST;
          upper_tmp_reg <= ocau_pkg::WORD_RST;
          count_current_stage_reg <= ocau_pkg::MUL_COUNT;
          add_pend_reg <= 1'b0;
          state_reg <= ST_MUL_ADD;
        end
        ST_MUL_ADD:
        begin
          // magnitudes below 2^17 each, so the sum cannot leave 18 bits
          if (add_pend_reg)
            upper_word_register_reg <= add_sum;
          state_reg <= ST_CLR_NEXT;
        end
        ST_CLR_NEXT:
        begin
          count_next_stage_reg <= ocau_pkg::CNT_RST;
          state_reg <= ST_LOAD_NEXT;
        end
        ST_LOAD_NEXT:
        begin
          count_next_stage_reg <= count_current_stage_reg - 6'h01;
          upper_tmp_reg <= ocau_pkg::WORD_RST;
          lower_tmp_reg <= ocau_pkg::WORD_RST;
          state_reg <= ST_TO_TEMP;
        end
        ST_TO_TEMP:
        begin
          // pair shifts right as one, the upper low bit moving down
          upper_tmp_reg <= pair[35:18] >> 1;
          lower_tmp_reg <= pair[18:1];
          // multiplier bit caught before it falls off the bottom
          add_pend_reg <= low_word_register_reg[0];
          state_reg <= ST_COPY_CNT;
        end
        ST_COPY_CNT:
        begin
          count_current_stage_reg <= count_next_stage_reg;
          upper_word_register_reg <= ocau_pkg::WORD_RST;
          low_word_register_reg <= ocau_pkg::WORD_RST;
          state_reg <= ST_RETURN;
        end
        ST_RETURN:
        begin
          upper_word_register_reg <= upper_tmp_reg;
          low_word_register_reg <= lower_tmp_reg;
          state_reg <= ST_TEST;
        end
        ST_TEST:
        begin
          // loop until the count has run out
          if (count_current_stage_reg == ocau_pkg::CNT_RST)
            state_reg <= ST_MUL_FIX;
          else
            state_reg <= ST_MUL_ADD;
        end
        ST_MUL_FIX:
        begin
          if (sign_a_reg ^ sign_b_reg)
          begin
            upper_word_register_reg <= pair_inv[35:18];
            low_word_register_reg <= pair_inv[17:0];
          end
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_DIV_SETUP:
        begin
          sign_a_reg <= up_neg;
          sign_b_reg <= m0_neg;
          upper_word_register_reg <= pair_mag[35:18];
          low_word_register_reg <= pair_mag[17:0];
          latch_reg <= ~m0_mag;
          count_current_stage_reg <= ocau_pkg::DIV_COUNT;
          div_ovf_reg <= 1'b0;
          state_reg <= ST_DIV_CHECK;
        end
        ST_DIV_CHECK:
        begin
          // upper word not below divisor: quotient cannot fit
          if (!add_borrow)
          begin
            div_ovf_reg <= 1'b1;
            low_word_register_reg <= ocau_pkg::WORD_RST;
            state_reg <= ST_DIV_FIX;
          end
          else
            state_reg <= ST_DIV_STEP;
        end
        ST_DIV_STEP:
        begin
          count_current_stage_reg <= count_current_stage_reg - 6'h01;
          if (add_borrow)
          begin
            upper_word_register_reg <= pair_shl[35:18];
            low_word_register_reg <= pair_shl[17:0];
          end
          else
          begin
            upper_word_register_reg <= add_sum;
            low_word_register_reg <= {pair_shl[17:1], 1'b1};
          end
          if (cnt_last)
            state_reg <= ST_DIV_FIX;
        end
        ST_DIV_FIX:
        begin
          // overflow keeps the +0 quotient as it is
          if (!div_ovf_reg && (sign_a_reg ^ sign_b_reg))
            low_word_register_reg <= ~low_word_register_reg;
          if (sign_a_reg)
            upper_word_register_reg <= ~upper_word_register_reg;
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_SH_TEMP:
        begin
          upper_tmp_reg <= shl_reg ? up_shl : up_shr;
          count_current_stage_reg <= count_current_stage_reg - 6'h01;
          state_reg <= ST_SH_BACK;
        end
        ST_SH_BACK:
        begin
          upper_word_register_reg <= upper_tmp_reg;
          if (count_current_stage_reg == ocau_pkg::CNT_RST)
          begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else
            state_reg <= ST_SH_TEMP;
        end
        default:
        begin
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign rd_data_out = rd_data_reg;
  assign busy_out = busy_reg;
  assign overflow_out = overflow_reg;
endmodule : ocau_arith_unit
`default_nettype wire

// [ocau_arith_unit_properties.sv]
// Purpose: port timing checks for the ones-complement arithmetic unit
// Assumes: busy lengths as handed over with the design
// Notes: a helper counter measures each busy stretch
`timescale 1ns/1ps
`default_nettype none
module ocau_arith_unit_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [17:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [17:0] rd_data_out,
  input wire logic busy_out,
  input wire logic overflow_out
);
  logic [17:0] cmd_reg;
  logic [7:0] cnt_reg;
  wire logic take = wr_en_in && addr_in == ocau_pkg::REG_CMD && !busy_out;
  wire logic [17:0] cmd_next = take ? wr_data_in : cmd_reg;
  wire logic [7:0] cnt_next = busy_out ? cnt_reg + 8'h01 : 8'h00;
  wire logic is_mul = cmd_reg[17:13] == ocau_pkg::OP_MUL_A[5:1];
  wire logic is_div = cmd_reg[17:13] == ocau_pkg::OP_DIV_A[5:1];
  wire logic is_shift = cmd_reg[17:12] == ocau_pkg::OP_EXT;
  wire logic ovf_clear = wr_en_in && addr_in == ocau_pkg::REG_STATUS
    && wr_data_in[ocau_pkg::ST_OVF_BIT];
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_reg <= 18'h00000;
      cnt_reg <= 8'h00;
    end
    else
    begin
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_take_single;
    take && wr_data_in[17:14] == ocau_pkg::OP_ADD_A[5:2];
  endsequence
  sequence s_take_double;
    take && wr_data_in[17:14] == ocau_pkg::OP_DADD_A[5:2];
  endsequence
  sequence s_take_zero_shift;
    take && wr_data_in[17:12] == ocau_pkg::OP_EXT && wr_data_in[5:0] == 6'h00;
  endsequence
  sequence s_done;
    $fell(busy_out);
  endsequence
  chk_single_busy: assert property (s_take_single |=> busy_out ##1 !busy_out)
    else $error("single length add busy length wrong");
  chk_double_busy: assert property (s_take_double |=> busy_out [*2] ##1 !busy_out)
    else $error("double length add busy length wrong");
  chk_mul_length: assert property (s_done ##0 is_mul |-> cnt_reg == 8'h87)
    else $error("multiply pass count wrong");
  chk_div_length: assert property (s_done ##0 is_div |-> cnt_reg inside {8'h15, 8'h03})
    else $error("divide step count wrong");
  chk_div_overflow: assert property (s_done ##0 is_div && cnt_reg == 8'h03 |-> overflow_out)
    else $error("short divide without overflow");
  chk_shift_length: assert property (s_done ##0 is_shift |-> cnt_reg == {1'b0, cmd_reg[5:0], 1'b0})
    else $error("shift count not honoured");
  chk_zero_shift: assert property (s_take_zero_shift |=> !busy_out [*3])
    else $error("zero count shift went busy");
  chk_ovf_sticky: assert property (overflow_out && !ovf_clear |=> overflow_out)
    else $error("overflow flag dropped");
  chk_ovf_source: assert property ($rose(overflow_out) |-> is_div)
    else $error("overflow raised outside divide");
endmodule : ocau_arith_unit_checker
bind ocau_arith_unit ocau_arith_unit_checker i_ocau_arith_unit_checker (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .busy_out(busy_out),
  .overflow_out(overflow_out));
`default_nettype wire

// [ocau_seq_model.sv]
// Purpose: sequencer and core memory stand-in at the far side
// Assumes: operand pairs start at an even address
// Notes: skip decisions follow the overflow flag
`timescale 1ns/1ps
`default_nettype none
module ocau_seq_model (
  input wire logic core_clk_in,
  input wire logic ld_in,
  input wire logic [2:0] y_in,
  input wire logic [17:0] word_in,
  input wire logic overflow_in,
  output logic [17:0] y_word_out,
  output logic [17:0] y1_word_out,
  output logic skip_ovf_out,
  output logic skip_no_ovf_out
);
  logic [17:0] mem_reg [8];
  always_ff @(posedge core_clk_in)
  begin
    if (ld_in)
    begin
      mem_reg[y_in] <= word_in;
    end
  end
  // odd y is forced even: the high half always sits one above
  assign y_word_out = mem_reg[{y_in[2:1], 1'b0}];
  assign y1_word_out = mem_reg[{y_in[2:1], 1'b1}];
  assign skip_ovf_out = overflow_in;
  assign skip_no_ovf_out = !overflow_in;
endmodule : ocau_seq_model
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for the ones-complement arithmetic unit
// Assumes: register map and busy lengths of the design hand-over
// Notes: divide operands kept below quotient overflow except on purpose
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [17:0] wr_data_in = 18'h00000;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [17:0] rd_data_out;
  logic busy_out;
  logic overflow_out;
  logic ld = 1'b0;
  logic [2:0] ysel = 3'h2;
  logic [17:0] mword = 18'h00000;
  logic [17:0] yw;
  logic [17:0] y1w;
  logic skip_ovf;
  logic skip_nov;
  logic [17:0] ru;
  logic [17:0] rl;
  int n_errors = 0;
  int n_checks = 0;
  always #2 core_clk_in = ~core_clk_in;
  ocau_arith_unit i_ocau_arith_unit (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .busy_out(busy_out), .overflow_out(overflow_out));
  ocau_seq_model i_ocau_seq_model (.core_clk_in(core_clk_in), .ld_in(ld), .y_in(ysel),
    .word_in(mword), .overflow_in(overflow_out), .y_word_out(yw), .y1_word_out(y1w),
    .skip_ovf_out(skip_ovf), .skip_no_ovf_out(skip_nov));
  function automatic logic [17:0] oc_sub(input logic [17:0] x, input logic [17:0] y);
    // end-around borrow: a subtractive adder yields minus zero only for minus zero less plus zero
    return (x >= y) ? x - y : x - y - 18'h00001;
  endfunction : oc_sub
  function automatic logic [17:0] oc_add(input logic [17:0] x, input logic [17:0] y);
    return oc_sub(x, ~y);
  endfunction : oc_add
  function automatic logic [17:0] mag(input logic [17:0] x);
    return x[17] ? ~x : x;
  endfunction : mag
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [17:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [17:0] d);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1 d = rd_data_out;
    @(posedge core_clk_in);
  endtask : rd
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge core_clk_in);
      #1;
      if (busy_out === 1'b0)
        break;
    end
    if (i == 400)
    begin
      check("busy_done", {35'h0, busy_out}, 36'h0);
      end_of_test();
    end
    @(posedge core_clk_in);
  endtask : wait_idle
  task automatic op(input logic [17:0] cmd, input logic [17:0] u, input logic [17:0] l,
    input logic [17:0] m0, input logic [17:0] m1, input bit poke);
    ld <= 1'b1;
    ysel <= 3'h2;
    mword <= m0;
    @(posedge core_clk_in);
    ysel <= 3'h3;
    mword <= m1;
    @(posedge core_clk_in);
    ld <= 1'b0;
    ysel <= 3'h2;
    @(posedge core_clk_in);
    wr(ocau_pkg::REG_MEM0, yw);
    wr(ocau_pkg::REG_MEM1, y1w);
    wr(ocau_pkg::REG_UPPER, u);
    wr(ocau_pkg::REG_LOWER, l);
    wr(ocau_pkg::REG_CMD, cmd);
    if (poke)
    begin
      // both must be dropped while the command runs
      wr(ocau_pkg::REG_CMD, {ocau_pkg::OP_ADD_A, 12'h000});
      wr(ocau_pkg::REG_LOWER, 18'h3ffff);
    end
    wait_idle();
    rd(ocau_pkg::REG_UPPER, ru);
    rd(ocau_pkg::REG_LOWER, rl);
  endtask : op
  initial
  begin
    logic [17:0] a, b, c, e, m, v, lo, hi;
    logic [35:0] p, dv;
    int k, seed_v;
    bit s, sd, sv;
    seed_v = $urandom(57);
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    for (k = 0; k < 7; k++)
    begin
      rd(3'(k), v);
      check("reset_word", v, 36'h0);
    end
    for (k = 0; k < 16; k++)
    begin
      a = (k == 0) ? 18'h00005 : 18'($urandom);
      b = (k == 0) ? 18'h3fffa : 18'($urandom);
      c = 18'($urandom);
      e = 18'($urandom);
      s = k[1];
      lo = s ? oc_sub(a, b) : oc_add(a, b);
      hi = (k < 8) ? c : (s ? oc_sub(c, e) : oc_add(c, e));
      op({((k < 8) ? ocau_pkg::OP_ADD_A : ocau_pkg::OP_DADD_A) + 6'(k % 4), 12'h000},
        c, a, b, e, 1'b0);
      check("add_pair", {ru, rl}, {hi, lo});
    end
    for (k = 0; k < 6; k++)
    begin
      a = (k == 0) ? 18'h1ffff : 18'($urandom);
      b = (k == 0) ? 18'h20000 : 18'($urandom);
      p = {18'h0, mag(a)} * {18'h0, mag(b)};
      op({ocau_pkg::OP_MUL_A + 6'(k % 2), 12'h000}, 18'($urandom), a, b, 18'h0, k == 1);
      check("product", {ru, rl}, (a[17] ^ b[17]) ? ~p : p);
    end
    for (k = 0; k < 10; k++)
    begin
      m = (k < 2) ? 18'h00007 + 18'(k * 2) : 18'($urandom_range(32'h1ffff, 4));
      hi = (k < 2) ? 18'h00000 : 18'($urandom) % (m >> 1);
      lo = (k < 2) ? 18'h00005 + 18'(k * 4) : 18'($urandom) & 18'h1ffff;
      sd = k[1];
      sv = k[2];
      dv = {hi, lo};
      p = dv / {18'h0, m};
      c = p[17:0];
      e = 18'(dv % {18'h0, m});
      dv = sd ? ~dv : dv;
      op({ocau_pkg::OP_DIV_A + 6'(k % 2), 12'h000}, dv[35:18], dv[17:0],
        sv ? ~m : m, 18'h0, k == 3);
      check("quot_rem", {ru, rl}, {sd ? ~e : e, (sd ^ sv) ? ~c : c});
      check("no_overflow", {35'h0, overflow_out}, 36'h0);
      check("skip_on_no_ovf", {skip_nov, skip_ovf}, 36'h2);
    end
    for (k = 0; k < 2; k++)
    begin
      op({ocau_pkg::OP_DIV_A, 12'h000}, 18'h00005, 18'($urandom), 18'(3 * k), 18'h0, 1'b0);
      check("ovf_lower", rl, 36'h0);
      check("skip_on_ovf", {skip_nov, skip_ovf}, 36'h1);
      rd(ocau_pkg::REG_STATUS, v);
      check("status", v, 36'h2);
      wr(ocau_pkg::REG_STATUS, 18'h00002);
      check("rd_back_zero", rd_data_out, 36'h0);
      check("ovf_cleared", {35'h0, overflow_out}, 36'h0);
    end
    for (k = 0; k < 12; k++)
    begin
      a = 18'($urandom);
      b = 18'($urandom);
      e = (k < 8) ? 18'(k / 2 * 17 - (k / 4) * 16) : 18'($urandom_range(63, 0));
      p = {a, a} << (e % 18);
      hi = k[0] ? p[35:18] : 18'($signed(a) >>> e);
      op({ocau_pkg::OP_EXT, k[0] ? ocau_pkg::SUB_SHL_UP : ocau_pkg::SUB_SHR_UP, e[5:0]},
        a, b, 18'h0, 18'h0, 1'b0);
      check("shift_pair", {ru, rl}, {hi, b});
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
